// >>> logic/audio_signal_path_processing.sv
/*
 * Audio signal network: gain, high-pass, mixing and loss stages, level
 * regulator and equalizer, plus the output frame FIFO.
 * Assumes one sample frame per accepted input beat and a host that uses
 * the single-cycle register port with read data one cycle later.
 */
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps

module frame_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;

    assign out_valid = (wr_ff != rd_ff);
    assign in_ready  = !((wr_ff[AW] != rd_ff[AW]) &&
                         (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
    assign out_data  = mem_ff[rd_ff[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            mem_ff[wr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_ff <= rd_ff + 1'b1;
            end
        end
    end
endmodule

module audio_signal_path_processing (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    // Register port
    input  wire logic [4:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_we,
    input  wire logic                     reg_re,
    output logic [15:0]                   reg_rdata,
    // Incoming sample frames
    input  wire audio_path_pkg::frame_type in_frame,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    // Outgoing sample frames
    output audio_path_pkg::frame_type     out_frame,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    // Digital channel 1 mode
    output logic                          sync_serial_mode
);
    import audio_path_pkg::*;

    logic [15:0] cfg_ff [0:19];
    logic [5:0]  coef_idx_ff;
    logic signed [15:0] coef_mem_ff [0:35];
    sample_type  sig_ff [0:31];
    sample_type  hp_x_ff [0:3];
    sample_type  hp_y_ff [0:3];
    sample_type  nxt_hp_y [0:3];
    logic [15:0] lvl_gain_ff;
    logic [15:0] env_ff;
    logic [15:0] out_lvl_ff;
    logic        regulating;
    eq_state_type eq_state_ff;
    logic [5:0]  eq_k_ff;
    logic signed [39:0] acc_ff;
    sample_type  eq_x_ff [0:8];
    sample_type  eq_w_ff [0:16];
    logic        fifo_ready;
    logic        take;
    logic        coef_hit;
    logic [15:0] nxt_rdata;
    sample_type  nxt_sum;
    sample_type  nxt_lvl_out;
    logic signed [39:0] mac_term;
    logic [15:0] gain_min;
    logic [15:0] gain_max;

    function automatic sample_type sat16(input logic signed [39:0] v);
        if (v > 40'sd32767) begin
            return 16'sh7FFF;
        end else if (v < -40'sd32768) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction

    function automatic sample_type gain_mul(input sample_type x,
                                            input logic [15:0] g);
        logic signed [39:0] p;
        p = 40'(x) * 40'($signed(g));
        return sat16(p >>> GAIN_FRAC);
    endfunction

    // Linear loss: setting 0 passes 255/256 of the signal, full scale mutes it
    function automatic sample_type loss8(input sample_type x,
                                         input logic [7:0] a);
        logic signed [39:0] p;
        p = 40'(x) * 40'($signed({1'b0, ~a}));
        return sat16(p >>> 8);
    endfunction

    function automatic logic [15:0] shr_tau(input logic signed [16:0] v,
                                            input logic [6:0] tau);
        logic [3:0] s;
        s = (tau > 7'h0F) ? 4'hF : tau[3:0];
        return 16'(v >>> s);
    endfunction

    function automatic logic [15:0] mag(input sample_type x);
        return x[15] ? 16'(-$signed({x[15], x})) : 16'(x);
    endfunction

    function automatic logic [4:0] fld5(input logic [15:0] r,
                                        input int pos);
        return 5'(r >> pos);
    endfunction

    assign sync_serial_mode = cfg_ff[A_DIG_MODE][0];
    assign regulating = cfg_ff[A_LVL_CTRL][LVL_EN_POS] &&
                        (env_ff[15:8] > cfg_ff[A_LVL_P4][14:7]);
    assign in_ready = fifo_ready && (eq_state_ff == EQ_IDLE);
    assign take     = in_valid && in_ready;
    assign coef_hit = (reg_we || reg_re) && (reg_addr == A_EQ_COEF);
    assign gain_min = LVL_UNITY - {8'h00, cfg_ff[A_LVL_P3][7:0]};
    assign gain_max = LVL_UNITY + {8'h00, cfg_ff[A_LVL_P3][14:8], 1'b0};

    // Register writes; coefficient data lives in its own array
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 20; i++) begin
                cfg_ff[i] <= REG_RST;
            end
            cfg_ff[A_GAIN_CH1_IN]  <= GAIN_RST;
            cfg_ff[A_GAIN_CH1_OUT] <= GAIN_RST;
            cfg_ff[A_GAIN_CH2_IN]  <= GAIN_RST;
            cfg_ff[A_GAIN_CH2_OUT] <= GAIN_RST;
        end else if (reg_we && reg_addr < A_STATUS &&
                     reg_addr != A_EQ_COEF && reg_addr != A_EQ_CTRL) begin
            cfg_ff[reg_addr] <= reg_wdata;
        end else if (reg_we && reg_addr == A_EQ_CTRL) begin
            cfg_ff[A_EQ_CTRL] <= {4'h0, reg_wdata[11:0] & 12'h03F};
        end
    end

    // Index lives apart from the control word so it can auto-advance
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            coef_idx_ff <= IDX_RST;
        end else if (reg_we && reg_addr == A_EQ_CTRL) begin
            coef_idx_ff <= reg_wdata[EQ_IDX_POS +: 6];
        end else if (coef_hit) begin
            if (coef_idx_ff < N_COEF) begin
                coef_idx_ff <= coef_idx_ff + 6'h01;
            end else begin
                coef_idx_ff <= IDX_RST;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 36; i++) begin
                coef_mem_ff[i] <= 16'sh0000;
            end
        end else if (reg_we && reg_addr == A_EQ_COEF &&
                     coef_idx_ff < N_COEF) begin
            coef_mem_ff[coef_idx_ff] <= reg_wdata;
        end
    end

    always_comb begin
        nxt_rdata = 16'h0000;
        if (reg_addr == A_EQ_COEF) begin
            if (coef_idx_ff < N_COEF) begin
                nxt_rdata = coef_mem_ff[coef_idx_ff];
            end
        end else if (reg_addr == A_EQ_CTRL) begin
            nxt_rdata = {4'h0, coef_idx_ff, cfg_ff[A_EQ_CTRL][5:0]};
        end else if (reg_addr == A_STATUS) begin
            nxt_rdata = {13'h0000, !out_valid, regulating,
                         (eq_state_ff != EQ_IDLE)};
        end else if (reg_addr < A_STATUS) begin
            nxt_rdata = cfg_ff[reg_addr];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_re) begin
            reg_rdata <= nxt_rdata;
        end
    end

    // High-pass per incoming signal; analog inputs get their gain first
    always_comb begin
        sample_type x [0:3];
        logic       en [0:3];
        x[0] = gain_mul(in_frame.ana1, cfg_ff[A_GAIN_CH1_IN]);
        x[1] = gain_mul(in_frame.ana2, cfg_ff[A_GAIN_CH2_IN]);
        x[2] = in_frame.dig1;
        x[3] = in_frame.dig2;
        en[0] = cfg_ff[A_ROUTE_CH1][ROUTE_HP_POS];
        en[1] = cfg_ff[A_ROUTE_CH2][ROUTE_HP_POS];
        en[2] = cfg_ff[A_DROUTE_CH1][ROUTE_HP_POS];
        en[3] = cfg_ff[A_DROUTE_CH2][ROUTE_HP_POS];
        for (int i = 0; i < 4; i++) begin
            nxt_hp_y[i] = en[i] ? sat16(40'(x[i]) - 40'(hp_x_ff[i]) +
                          40'(hp_y_ff[i]) - 40'(hp_y_ff[i] >>> HP_SHIFT))
                        : x[i];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 4; i++) begin
                hp_x_ff[i] <= 16'sh0000;
                hp_y_ff[i] <= 16'sh0000;
            end
        end else if (take) begin
            hp_x_ff[0] <= gain_mul(in_frame.ana1, cfg_ff[A_GAIN_CH1_IN]);
            hp_x_ff[1] <= gain_mul(in_frame.ana2, cfg_ff[A_GAIN_CH2_IN]);
            hp_x_ff[2] <= in_frame.dig1;
            hp_x_ff[3] <= in_frame.dig2;
            for (int i = 0; i < 4; i++) begin
                hp_y_ff[i] <= nxt_hp_y[i];
            end
        end
    end

    // Sum point and regulated output, fed from last frame's signals
    always_comb begin
        logic [15:0] c;
        c = cfg_ff[A_LVL_CTRL];
        nxt_sum = sat16(40'(sig_ff[fld5(c, LVL_SEL_A_POS)]) +
                  40'((40'(sig_ff[fld5(c, LVL_SEL_B_POS)]) *
                  $signed({1'b0, ~cfg_ff[A_LVL_LOSS][14:0]})) >>> 15));
        nxt_lvl_out = c[LVL_EN_POS] ? sat16(40'(nxt_sum) *
                      $signed({1'b0, lvl_gain_ff}) >>> 8) : 16'sh0000;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            env_ff      <= 16'h0000;
            out_lvl_ff  <= 16'h0000;
            lvl_gain_ff <= LVL_UNITY;
        end else if (!cfg_ff[A_LVL_CTRL][LVL_EN_POS]) begin
            lvl_gain_ff <= {7'h00, cfg_ff[A_LVL_P1][7:0], 1'b0};
            env_ff      <= 16'h0000;
            out_lvl_ff  <= 16'h0000;
        end else if (take) begin
            env_ff <= env_ff + shr_tau($signed({1'b0, mag(nxt_sum)}) -
                      $signed({1'b0, env_ff}), cfg_ff[A_LVL_P4][6:0]);
            out_lvl_ff <= out_lvl_ff + shr_tau(
                          $signed({1'b0, mag(nxt_lvl_out)}) -
                          $signed({1'b0, out_lvl_ff}),
                          cfg_ff[A_LVL_P5][6:0]);
            if (regulating) begin
                if (out_lvl_ff[15:8] > cfg_ff[A_LVL_P1][15:8]) begin
                    lvl_gain_ff <= (lvl_gain_ff > gain_min +
                                   cfg_ff[A_LVL_P2][15:8]) ?
                                   lvl_gain_ff - cfg_ff[A_LVL_P2][15:8]
                                   : gain_min;
                end else begin
                    lvl_gain_ff <= (lvl_gain_ff + cfg_ff[A_LVL_P2][7:0] <
                                   gain_max) ?
                                   lvl_gain_ff + cfg_ff[A_LVL_P2][7:0]
                                   : gain_max;
                end
            end
        end
    end

    // Internal signal network, one frame of latency between stages
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 32; i++) begin
                sig_ff[i] <= 16'sh0000;
            end
        end else if (take) begin
            sig_ff[S_ANA1_IN] <= nxt_hp_y[0];
            sig_ff[S_ANA2_IN] <= nxt_hp_y[1];
            sig_ff[S_DIG1_IN] <= nxt_hp_y[2];
            sig_ff[S_DIG2_IN] <= nxt_hp_y[3];
            sig_ff[S_ANA1_OUT] <= gain_mul(mix3(cfg_ff[A_ROUTE_CH1]),
                                           cfg_ff[A_GAIN_CH1_OUT]);
            sig_ff[S_ANA2_OUT] <= gain_mul(mix3(cfg_ff[A_ROUTE_CH2]),
                                           cfg_ff[A_GAIN_CH2_OUT]);
            sig_ff[S_DIG1_OUT] <= mixd(cfg_ff[A_DROUTE_CH1],
                                      cfg_ff[A_ECHO_LOSS][7:0]);
            sig_ff[S_DIG2_OUT] <= mixd(cfg_ff[A_DROUTE_CH2],
                                      cfg_ff[A_ECHO_LOSS][15:8]);
            sig_ff[S_SPARE] <= loss8(sig_ff[fld5(cfg_ff[A_SPARE_LOSS],
                               SPARE_SEL_POS)],
                               cfg_ff[A_SPARE_LOSS][7:0]);
            sig_ff[S_SUM]     <= nxt_sum;
            sig_ff[S_LVL_OUT] <= nxt_lvl_out;
        end else if (eq_state_ff == EQ_DONE) begin
            sig_ff[S_EQ] <= cfg_ff[A_EQ_CTRL][EQ_EN_POS] ?
                            sat16(acc_ff) : 16'sh0000;
        end
    end

    function automatic sample_type mix3(input logic [15:0] r);
        return sat16(40'(sig_ff[fld5(r, SEL_A_POS)]) +
                     40'(sig_ff[fld5(r, SEL_B_POS)]) +
                     40'(sig_ff[fld5(r, SEL_C_POS)]));
    endfunction

    function automatic sample_type mixd(input logic [15:0] r,
                                       input logic [7:0] a);
        return sat16(40'(sig_ff[fld5(r, SEL_A_POS)]) +
                     40'(sig_ff[fld5(r, SEL_B_POS)]) +
                     40'(loss8(sig_ff[fld5(r, SEL_C_POS)], a)));
    endfunction

    // Equalizer: one multiply per cycle over 36 coefficients per frame,
    // trading latency for a single multiplier
    always_comb begin
        sample_type d;
        d = 16'sh0000;
        if (eq_k_ff <= 6'h08) begin
            d = eq_x_ff[eq_k_ff[3:0]];
        end else if (eq_k_ff <= C_FB_LAST) begin
            d = eq_w_ff[5'(eq_k_ff - 6'h08)];
        end else if (eq_k_ff >= C_FIR0 && eq_k_ff < C_SCALE2) begin
            d = eq_w_ff[5'(eq_k_ff - C_FIR0)];
        end
        mac_term = 40'(d) * 40'(coef_mem_ff[eq_k_ff]);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            eq_state_ff <= EQ_IDLE;
            eq_k_ff     <= 6'h00;
            acc_ff      <= 40'sh0000000000;
            for (int i = 0; i < 9; i++) begin
                eq_x_ff[i] <= 16'sh0000;
            end
            for (int i = 0; i < 17; i++) begin
                eq_w_ff[i] <= 16'sh0000;
            end
        end else begin
            unique case (eq_state_ff)
                EQ_IDLE: begin
                    if (take) begin
                        eq_x_ff[0] <= sig_ff[fld5(cfg_ff[A_EQ_CTRL],
                                      EQ_SEL_POS)];
                        for (int i = 1; i < 9; i++) begin
                            eq_x_ff[i] <= eq_x_ff[i-1];
                        end
                        for (int i = 1; i < 17; i++) begin
                            eq_w_ff[i] <= eq_w_ff[i-1];
                        end
                        acc_ff      <= 40'sh0000000000;
                        eq_k_ff     <= 6'h00;
                        eq_state_ff <= EQ_RUN;
                    end
                end
                EQ_RUN: begin
                    eq_k_ff <= eq_k_ff + 6'h01;
                    if (eq_k_ff == C_SCALE1) begin
                        eq_w_ff[0] <= sat16((40'(sat16(acc_ff >>> COEF_FRAC))
                                      * 40'(coef_mem_ff[C_SCALE1]))
                                      >>> COEF_FRAC);
                        acc_ff <= 40'sh0000000000;
                    end else if (eq_k_ff == C_SCALE2) begin
                        acc_ff <= (40'(sat16(acc_ff >>> COEF_FRAC)) *
                                  40'(coef_mem_ff[C_SCALE2])) >>> COEF_FRAC;
                        eq_state_ff <= EQ_DONE;
                    end else begin
                        acc_ff <= acc_ff + mac_term;
                    end
                end
                EQ_DONE: begin
                    eq_state_ff <= EQ_IDLE;
                end
                default: begin
                    eq_state_ff <= EQ_IDLE;
                end
            endcase
        end
    end

    // Output frame pushed once the equalizer pass ends; room is guaranteed
    // because a frame is only taken while the FIFO has a free slot
    frame_fifo #(
        .WIDTH (64),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_valid  (eq_state_ff == EQ_DONE),
        .in_ready  (fifo_ready),
        .in_data   ({sig_ff[S_ANA1_OUT], sig_ff[S_ANA2_OUT],
                     sig_ff[S_DIG1_OUT], sig_ff[S_DIG2_OUT]}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_frame)
    );

endmodule

// >>> logic/audio_path_pkg.sv
/*
 * Shared constants and types of the audio signal network: register
 * indices, field positions, reset values, source codes and the frame type.
 * Assumes a 16-bit register port and signed 16-bit PCM samples.
 */
package audio_path_pkg;

    typedef logic signed [15:0] sample_type;

    typedef struct packed {
        sample_type ana1;
        sample_type ana2;
        sample_type dig1;
        sample_type dig2;
    } frame_type;

    typedef enum logic [1:0] {
        EQ_IDLE = 2'b00,
        EQ_RUN  = 2'b01,
        EQ_DONE = 2'b10
    } eq_state_type;

    // Register indices on the register port
    localparam logic [4:0] A_GAIN_CH1_IN   = 5'h00;
    localparam logic [4:0] A_GAIN_CH1_OUT  = 5'h01;
    localparam logic [4:0] A_ROUTE_CH1     = 5'h02;
    localparam logic [4:0] A_GAIN_CH2_IN   = 5'h03;
    localparam logic [4:0] A_GAIN_CH2_OUT  = 5'h04;
    localparam logic [4:0] A_ROUTE_CH2     = 5'h05;
    localparam logic [4:0] A_DROUTE_CH1    = 5'h06;
    localparam logic [4:0] A_DROUTE_CH2    = 5'h07;
    localparam logic [4:0] A_ECHO_LOSS     = 5'h08;
    localparam logic [4:0] A_SPARE_LOSS    = 5'h09;
    localparam logic [4:0] A_LVL_CTRL      = 5'h0A;
    localparam logic [4:0] A_LVL_LOSS      = 5'h0B;
    localparam logic [4:0] A_LVL_P1        = 5'h0C;
    localparam logic [4:0] A_LVL_P2        = 5'h0D;
    localparam logic [4:0] A_LVL_P3        = 5'h0E;
    localparam logic [4:0] A_LVL_P4        = 5'h0F;
    localparam logic [4:0] A_LVL_P5        = 5'h10;
    localparam logic [4:0] A_EQ_CTRL       = 5'h11;
    localparam logic [4:0] A_EQ_COEF       = 5'h12;
    localparam logic [4:0] A_DIG_MODE      = 5'h13;
    localparam logic [4:0] A_STATUS        = 5'h14;

    // Field positions
    localparam int ROUTE_HP_POS   = 15;
    localparam int SEL_A_POS      = 0;
    localparam int SEL_B_POS      = 5;
    localparam int SEL_C_POS      = 10;
    localparam int LVL_EN_POS     = 0;
    localparam int LVL_SEL_A_POS  = 1;
    localparam int LVL_SEL_B_POS  = 6;
    localparam int EQ_EN_POS      = 0;
    localparam int EQ_SEL_POS     = 1;
    localparam int EQ_IDX_POS     = 6;
    localparam int SPARE_SEL_POS  = 8;

    // Reset values
    localparam logic [15:0] GAIN_RST  = 16'h2000;
    localparam logic [15:0] REG_RST   = 16'h0000;
    localparam logic [5:0]  IDX_RST   = 6'h00;

    // Fixed-point scaling
    localparam int GAIN_FRAC = 13;
    localparam int COEF_FRAC = 14;
    localparam int HP_SHIFT  = 6;
    localparam logic [15:0] LVL_UNITY = 16'h0100;

    // Equalizer coefficient layout
    localparam logic [5:0] N_COEF    = 6'h24;
    localparam logic [5:0] C_FB_LAST = 6'h10;
    localparam logic [5:0] C_SCALE1  = 6'h11;
    localparam logic [5:0] C_SCALE2  = 6'h23;
    localparam logic [5:0] C_FIR0    = 6'h12;

    // Internal signal source codes
    localparam logic [4:0] S_ANA1_IN  = 5'h01;
    localparam logic [4:0] S_ANA1_OUT = 5'h02;
    localparam logic [4:0] S_ANA2_IN  = 5'h03;
    localparam logic [4:0] S_ANA2_OUT = 5'h04;
    localparam logic [4:0] S_DIG1_IN  = 5'h05;
    localparam logic [4:0] S_DIG1_OUT = 5'h06;
    localparam logic [4:0] S_DIG2_IN  = 5'h07;
    localparam logic [4:0] S_DIG2_OUT = 5'h08;
    localparam logic [4:0] S_SPARE    = 5'h0B;
    localparam logic [4:0] S_LVL_OUT  = 5'h10;
    localparam logic [4:0] S_SUM      = 5'h11;
    localparam logic [4:0] S_EQ       = 5'h12;

    localparam int FIFO_DEPTH = 16;

endpackage

// >>> dv/audio_path_checker.sv
/* Port checker for the audio network.
   Assumes it is bound to the top module; one clock domain. */
`timescale 1ns/1ps
module audio_path_checker
    import audio_path_pkg::*;
(
    // Clock, reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [15:0] reg_rdata,
    // Streams
    input wire audio_path_pkg::frame_type in_frame,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire audio_path_pkg::frame_type out_frame,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic sync_serial_mode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire take = in_valid && in_ready;
    wire wctl = reg_we && reg_addr == A_EQ_CTRL;
    wire rcoef = reg_re && reg_addr == A_EQ_COEF;
    wire rctl = reg_re && reg_addr == A_EQ_CTRL;
    wire wmode = reg_we && reg_addr == A_DIG_MODE;
    a_unmapped_zero: assert property (reg_re && reg_addr > A_STATUS
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_busy_after: assert property (take |=> !in_ready [*8])
        else $error("frame taken while busy");
    a_result_due: assert property (take && !out_valid
        |-> ##[30:45] out_valid) else $error("no output frame");
    a_out_hold: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_frame)) else $error("frame dropped");
    a_mode_set: assert property (wmode
        |=> sync_serial_mode == $past(reg_wdata[0])) else $error("mode bit");
    a_mode_keep: assert property (!wmode |=> $stable(sync_serial_mode))
        else $error("mode bit moved");
    a_idx_step: assert property (wctl && reg_wdata[11:6] < 6'h23
        ##1 rcoef ##1 rctl |=> reg_rdata[11:6] == $past(reg_wdata[11:6], 3)
        + 6'h01) else $error("index not advanced");
    a_idx_wrap: assert property (wctl && reg_wdata[11:6] >= N_COEF
        ##1 rcoef ##1 rctl |=> reg_rdata[11:6] == IDX_RST)
        else $error("index not reset");
endmodule

bind audio_signal_path_processing audio_path_checker u_chk (.*);

// >>> dv/codec_side_model.sv
/* Codec-side model: offers frames and drains output, stalling at first.
   Assumes the bench raises go once the registers are set. */
`timescale 1ns/1ps
module codec_side_model
    import audio_path_pkg::*;
(
    // Clock, reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Block side
    input wire logic in_ready,
    input wire logic out_valid,
    output audio_path_pkg::frame_type in_frame,
    output logic in_valid,
    output logic out_ready,
    // Bench side
    input wire logic go,
    input wire logic [31:0] rnd,
    output logic [7:0] sent_ff
);
    logic [11:0] cyc_ff;
    logic [7:0] nxt_sent;
    assign nxt_sent = sent_ff + {7'h00, in_valid && in_ready};
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cyc_ff <= 12'h000;
            sent_ff <= 8'h00;
            in_valid <= 1'b0;
            out_ready <= 1'b0;
            in_frame <= '0;
        end else if (go) begin
            cyc_ff <= cyc_ff + 12'h001;
            sent_ff <= nxt_sent;
            // Long stall first so the FIFO fills and must refuse
            out_ready <= cyc_ff > 12'h4B0 && cyc_ff[0];
            if (!in_valid || in_ready) begin
                in_valid <= nxt_sent < 8'h18;
                in_frame <= {16'h7000, rnd[15:0], 16'h1000, rnd[31:16]};
            end
        end
    end
endmodule

// >>> dv/audio_signal_path_processing_tb.sv
/* Bench: register port, coefficient index, mixing and FIFO fill.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module audio_signal_path_processing_tb;
    import audio_path_pkg::*;
    logic clk_sys = 1'b0, arst_n, reg_we = 1'b0, reg_re = 1'b0, re_d = 1'b0;
    logic in_ready, in_valid, out_valid, out_ready, sync_serial_mode;
    logic go = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [7:0] sent;
    logic [31:0] rnd = 32'h88C0D8F9;
    frame_type in_frame, out_frame;
    logic [15:0] rq[$];
    logic [63:0] fq[$];
    logic [15:0] cfg[11] = '{16'h2000, 16'h2000, 16'h0421, 16'h2000,
        16'h2000, 16'h0011, 16'h14A5, 16'h000B, 16'h00FF, 16'h0100,
        16'h000A};
    int fail_count = 0, tests_run = 0, cyc = 0, nout = 0;
    initial forever #25 clk_sys = ~clk_sys;
    audio_signal_path_processing DUT (.*);
    codec_side_model PEER (.*, .sent_ff(sent));
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [63:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic acc(input logic w, r, input logic [4:0] a,
                       input logic [15:0] d, e);
        @(posedge clk_sys);
        reg_we <= w;
        reg_re <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) rq.push_back(e);
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        rnd <= step(rnd);
        re_d <= reg_re;
        if (re_d) check("reg", reg_rdata, rq.pop_front());
        if (cyc == 1100) check("taken", sent, 16);
        if (cyc == 1100) check("mode", sync_serial_mode, 1);
        if (out_valid && out_ready) begin
            nout <= nout + 1;
            if (nout >= 4) check("frame", out_frame, fq.pop_front());
        end
        if (cyc == 8000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        logic [31:0] v;
        v = 32'h88C0D8F9;
        arst_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int a = 0; a < 21; a++)
            acc(0, 1, a[4:0], 0, (a == 20) ? 16'h0004 :
                (a inside {0, 1, 3, 4}) ? GAIN_RST : 16'h0000);
        for (int a = 0; a < 9; a++) begin
            v = step(v);
            acc(1, 0, a[4:0], v[15:0], 0);
            acc(0, 1, a[4:0], 0, v[15:0]);
        end
        acc(1, 0, 5'h1F, 16'hFFFF, 0);
        acc(0, 1, 5'h1F, 0, 0);
        acc(1, 0, A_DIG_MODE, 16'h0001, 0);
        acc(0, 1, A_DIG_MODE, 0, 16'h0001);
        acc(1, 0, A_EQ_CTRL, 16'h0880, 0);
        acc(0, 1, A_EQ_COEF, 0, 0);
        acc(0, 1, A_EQ_CTRL, 0, 16'h08C0);
        acc(1, 0, A_EQ_COEF, 16'hABCD, 0);
        acc(0, 1, A_EQ_COEF, 0, 0);
        acc(0, 1, A_EQ_CTRL, 0, 0);
        acc(1, 0, A_EQ_CTRL, 16'h0A00, 0);
        acc(0, 1, A_EQ_COEF, 0, 0);
        acc(0, 1, A_EQ_CTRL, 0, 0);
        acc(1, 0, A_EQ_CTRL, 16'h08C0, 0);
        acc(0, 1, A_EQ_COEF, 0, 16'hABCD);
        foreach (cfg[i]) acc(1, 0, i[4:0], cfg[i], 0);
        acc(0, 0, 0, 0, 0);
        // Triple sum saturates; echo input lost; sum point on ch2, spare on digital ch2
        repeat (20) fq.push_back({16'h7FFF, 16'h1000, 16'h2000, 16'h6F90});
        go <= 1'b1;
        while (nout < 24) @(posedge clk_sys);
        report_and_stop();
    end
endmodule
